// file: core/spwm_consts.svh
// constants for the stepper pwm configuration and status block
// Functional notes
// - PWM rate is 2/1024, 2/683, 2/512 or 2/410 of the clock for select 00, 01, 10, 11.
// - A back-EMF term, gradient times 256 divided by the measured step period, adds to amplitude.
// - The gradient from one-time memory is the power-up default, valid even with immediate quiet mode.
// - After automatic tuning the learned gradient is readable so software can save it as a seed.
// - The 8-bit standstill offset sits in bits 7..0, is referred to scale 31, and resets to 36.
// - A zero offset keeps the automatic scale from going below the motor lower measurement threshold.
// - A nonzero offset lets automatic scaling go down to low duty cycles below that threshold.
// - Status bit 31 flags standstill once 2^20 clocks passed since the last step, in every mode.
// - Status bit 30 reads 1 while the quiet chopper runs and 0 while the current chopper runs.
// - Status bits 20..16 show the actual current scale.
`ifndef SPWM_CONSTS_SVH
`define SPWM_CONSTS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define SPWM_ADDR_W        7
`define SPWM_STATUS_ADDR   7'h6f
`define SPWM_QUIET_CHOPPER_PWM_CONFIG_ADDR  7'h70
`define SPWM_PWMAUTO_ADDR  7'h72

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SPWM_OFS_LSB       0
`define SPWM_GRAD_LSB      8
`define SPWM_FREQ_LSB      16
`define SPWM_ASCALE_BIT    18
`define SPWM_AGRAD_BIT     19
`define SPWM_STST_BIT      31
`define SPWM_QUIET_BIT     30
`define SPWM_CS_LSB        16
`define SPWM_OFS_RST       8'h24
`define SPWM_CONF_RST      32'h000c_0024

// ----------------------------------------
// timing
// ----------------------------------------
`define SPWM_STST_CLKS     1048576
`define SPWM_CNT_W         21
`define SPWM_MEASURED_STEP_PERIOD_MAX     20'hfffff
`define SPWM_DIV_1024      11'h400
`define SPWM_DIV_683       11'h2ab
`define SPWM_DIV_512       11'h200
`define SPWM_DIV_410       11'h19a

`endif

// file: core/spwm_pkg.sv
// types for the stepper pwm configuration and status block
package spwm_pkg;
    typedef enum logic [1:0] {
        SPWM_RATE_1024,
        SPWM_RATE_683,
        SPWM_RATE_512,
        SPWM_RATE_410
    } spwm_rate_t;

    typedef logic [7:0]  spwm_byte_t;
    typedef logic [19:0] spwm_measured_step_period_t;
endpackage

// file: core/spwm_top.sv
// stepper pwm configuration, amplitude and driver status logic
`timescale 1ns/1ns
`include "spwm_consts.svh"

module spwm_top #(
    parameter int STST_CLKS = `SPWM_STST_CLKS
) (
    // clock, reset, enable
    input  wire logic                    clk_in,
    input  wire logic                    nrst_in,
    input  wire logic                    ce_in,
    // register access
    input  wire logic                    reg_wr_en_in,
    input  wire logic                    reg_rd_en_in,
    input  wire logic [`SPWM_ADDR_W-1:0] reg_addr_in,
    input  wire logic [31:0]             reg_wdata_in,
    output logic      [31:0]             reg_rdata_out,
    // one-time memory default
    input  wire logic [7:0]              otp_gradient_in,
    // motion and chopper inputs
    input  wire logic                    step_in,
    input  wire logic                    quiet_mode_in,
    input  wire logic [4:0]              hold_run_current_setting_hold_in,
    input  wire logic [4:0]              hold_run_current_setting_run_in,
    input  wire logic                    cur_above_in,
    input  wire logic                    cur_below_in,
    input  wire logic [7:0]              low_thresh_in,
    input  wire logic [14:0]             low_flags_in,
    // bridge side outputs
    output logic                         pwm_tick_out,
    output logic      [7:0]              pwm_amplitude_out,
    output logic      [4:0]              cs_actual_out,
    output logic                         standstill_out,
    output logic                         quiet_active_out
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [10:0] rate_div(input spwm_pkg::spwm_rate_t sel);
        case (sel)
            spwm_pkg::SPWM_RATE_1024: rate_div = `SPWM_DIV_1024;
            spwm_pkg::SPWM_RATE_683:  rate_div = `SPWM_DIV_683;
            spwm_pkg::SPWM_RATE_512:  rate_div = `SPWM_DIV_512;
            spwm_pkg::SPWM_RATE_410:  rate_div = `SPWM_DIV_410;
            default:                  rate_div = `SPWM_DIV_1024;
        endcase
    endfunction

    // back-emf term, saturated to a byte; a zero period never occurs but is guarded
    function automatic logic [7:0] emf_term(input logic [7:0] grad,
                                             input spwm_pkg::spwm_measured_step_period_t per);
        logic [27:0] q;
        q = 28'h0;
        if (per != 20'h0) begin
            q = {4'h0, grad, 16'h0} >> 8;
            q = q / {8'h0, per};
        end
        emf_term = (q > 28'hff) ? 8'hff : q[7:0];
    endfunction

    function automatic logic [7:0] sat_add(input logic [8:0] a, input logic [7:0] b);
        logic [9:0] s;
        s = {1'b0, a} + {2'h0, b};
        sat_add = (s > 10'hff) ? 8'hff : s[7:0];
    endfunction

    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    logic [31:0] conf_ff;
    logic [31:0] nxt_conf;
    logic        otp_done_ff;
    logic        nxt_otp_done;

    wire logic [7:0] cfg_ofs  = conf_ff[`SPWM_OFS_LSB +: 8];
    wire logic [7:0] cfg_grad = conf_ff[`SPWM_GRAD_LSB +: 8];
    wire logic       cfg_asc  = conf_ff[`SPWM_ASCALE_BIT];
    wire logic       cfg_agr  = conf_ff[`SPWM_AGRAD_BIT];
    wire spwm_pkg::spwm_rate_t cfg_rate =
        spwm_pkg::spwm_rate_t'(conf_ff[`SPWM_FREQ_LSB +: 2]);

    always_comb begin
        nxt_conf     = conf_ff;
        nxt_otp_done = 1'b1;
        if (!otp_done_ff) begin
            // gradient default arrives the first edge after reset, before any write
            nxt_conf[`SPWM_GRAD_LSB +: 8] = otp_gradient_in;
        end else if (reg_wr_en_in && reg_addr_in == `SPWM_QUIET_CHOPPER_PWM_CONFIG_ADDR) begin
            nxt_conf = reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            conf_ff     <= `SPWM_CONF_RST;
            otp_done_ff <= 1'b0;
        end else if (ce_in) begin
            conf_ff     <= nxt_conf;
            otp_done_ff <= nxt_otp_done;
        end
    end

    // ----------------------------------------
    // pwm rate generator
    // ----------------------------------------
    // counts in half clocks so the odd divisor 683 averages exactly
    logic [10:0] rate_acc_ff;
    logic [10:0] nxt_rate_acc;
    logic        tick_ff;
    logic        nxt_tick;

    always_comb begin
        logic [11:0] sum;
        sum          = {1'b0, rate_acc_ff} + 12'h2;
        nxt_rate_acc = sum[10:0];
        nxt_tick     = 1'b0;
        if (sum >= {1'b0, rate_div(cfg_rate)}) begin
            nxt_rate_acc = 11'(sum - {1'b0, rate_div(cfg_rate)});
            nxt_tick     = 1'b1;
        end
        // a switch to a faster rate can leave a stale count above the new divisor
        if (nxt_rate_acc >= rate_div(cfg_rate))
            nxt_rate_acc = 11'h0;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rate_acc_ff <= 11'h0;
            tick_ff     <= 1'b0;
        end else if (ce_in) begin
            rate_acc_ff <= nxt_rate_acc;
            tick_ff     <= nxt_tick;
        end
    end

    // ----------------------------------------
    // step period and standstill
    // ----------------------------------------
    logic [`SPWM_CNT_W-1:0]  since_ff;
    logic [`SPWM_CNT_W-1:0]  nxt_since;
    spwm_pkg::spwm_measured_step_period_t   measured_step_period_ff;
    spwm_pkg::spwm_measured_step_period_t   nxt_measured_step_period;
    logic                    stst_ff;
    logic                    nxt_stst;

    localparam logic [`SPWM_CNT_W-1:0] STST_LIM = `SPWM_CNT_W'(STST_CLKS);

    always_comb begin
        nxt_since = since_ff;
        nxt_measured_step_period = measured_step_period_ff;
        if (step_in) begin
            nxt_since = '0;
            if (since_ff >= `SPWM_CNT_W'(`SPWM_MEASURED_STEP_PERIOD_MAX))
                nxt_measured_step_period = `SPWM_MEASURED_STEP_PERIOD_MAX;
            else
                nxt_measured_step_period = since_ff[19:0] + 20'h1;
        end else if (since_ff < STST_LIM) begin
            nxt_since = since_ff + `SPWM_CNT_W'(1);
        end
        // slow motion must not keep an old short period forever
        if (!step_in && {1'b0, measured_step_period_ff} < since_ff)
            nxt_measured_step_period = (since_ff >= `SPWM_CNT_W'(`SPWM_MEASURED_STEP_PERIOD_MAX))
                        ? `SPWM_MEASURED_STEP_PERIOD_MAX : since_ff[19:0];
        nxt_stst = !step_in && nxt_since >= STST_LIM;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            since_ff <= '0;
            measured_step_period_ff <= `SPWM_MEASURED_STEP_PERIOD_MAX;
            stst_ff  <= 1'b0;
        end else if (ce_in) begin
            since_ff <= nxt_since;
            measured_step_period_ff <= nxt_measured_step_period;
            stst_ff  <= nxt_stst;
        end
    end

    // ----------------------------------------
    // current scale, chopper mode, automatic tuning
    // ----------------------------------------
    logic [4:0] cs_ff;
    logic [4:0] nxt_cs;
    logic       quiet_ff;
    logic       nxt_quiet;
    logic       asc_d_ff;
    logic       nxt_asc_d;
    logic [7:0] auto_ofs_ff;
    logic [7:0] nxt_auto_ofs;
    logic [7:0] lgrad_ff;
    logic [7:0] nxt_lgrad;
    logic [7:0] floor_v;

    always_comb begin
        nxt_cs = stst_ff ? hold_run_current_setting_hold_in
                         : hold_run_current_setting_run_in;
        nxt_quiet    = quiet_mode_in;
        nxt_asc_d    = cfg_asc;
        nxt_auto_ofs = auto_ofs_ff;
        nxt_lgrad    = lgrad_ff;
        // zero offset keeps regulation above the measurable floor
        floor_v = (cfg_ofs == 8'h0) ? low_thresh_in : 8'h0;
        if (!cfg_asc) begin
            // tuning follows the user values until autoscale is switched on
            nxt_auto_ofs = cfg_ofs;
            nxt_lgrad    = cfg_grad;
        end else if (tick_ff && quiet_ff) begin
            if (cur_above_in && auto_ofs_ff > floor_v) begin
                nxt_auto_ofs = auto_ofs_ff - 8'h1;
            end else if (cur_below_in && auto_ofs_ff != 8'hff) begin
                nxt_auto_ofs = auto_ofs_ff + 8'h1;
            end
            if (auto_ofs_ff < floor_v)
                nxt_auto_ofs = floor_v;
            if (cfg_agr && !stst_ff) begin
                if (cur_above_in && lgrad_ff != 8'h0)
                    nxt_lgrad = lgrad_ff - 8'h1;
                else if (cur_below_in && lgrad_ff != 8'hff)
                    nxt_lgrad = lgrad_ff + 8'h1;
            end
        end
        // autoscale is on from reset, so the learned gradient needs the same default
        if (!otp_done_ff)
            nxt_lgrad = otp_gradient_in;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cs_ff       <= 5'h0;
            quiet_ff    <= 1'b0;
            asc_d_ff    <= 1'b0;
            auto_ofs_ff <= `SPWM_OFS_RST;
            lgrad_ff    <= 8'h0;
        end else if (ce_in) begin
            cs_ff       <= nxt_cs;
            quiet_ff    <= nxt_quiet;
            asc_d_ff    <= nxt_asc_d;
            auto_ofs_ff <= nxt_auto_ofs;
            lgrad_ff    <= nxt_lgrad;
        end
    end

    // ----------------------------------------
    // amplitude
    // ----------------------------------------
    logic [7:0] ampl_ff;
    logic [7:0] nxt_ampl;

    always_comb begin
        logic [13:0] prod;
        prod = 14'({6'h0, cfg_ofs} * ({9'h0, cs_ff} + 14'h1));
        if (cfg_asc && asc_d_ff)
            nxt_ampl = sat_add({1'b0, auto_ofs_ff}, emf_term(lgrad_ff, measured_step_period_ff));
        else
            nxt_ampl = sat_add(prod[13:5], emf_term(cfg_grad, measured_step_period_ff));
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            ampl_ff <= 8'h0;
        else if (ce_in)
            ampl_ff <= nxt_ampl;
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd_en_in) begin
            case (reg_addr_in)
                `SPWM_STATUS_ADDR: begin
                    nxt_rdata = 32'h0;
                    nxt_rdata[`SPWM_STST_BIT]     = stst_ff;
                    nxt_rdata[`SPWM_QUIET_BIT]    = quiet_ff;
                    nxt_rdata[`SPWM_CS_LSB +: 5]  = cs_ff;
                    nxt_rdata[14:0]               = low_flags_in;
                end
                `SPWM_QUIET_CHOPPER_PWM_CONFIG_ADDR: nxt_rdata = conf_ff;
                `SPWM_PWMAUTO_ADDR: nxt_rdata = {8'h0, lgrad_ff, 8'h0, auto_ofs_ff};
                default:            nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            rdata_ff <= 32'h0;
        else if (ce_in)
            rdata_ff <= nxt_rdata;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata_out     = rdata_ff;
    assign pwm_tick_out      = tick_ff;
    assign pwm_amplitude_out = ampl_ff;
    assign cs_actual_out     = cs_ff;
    assign standstill_out    = stst_ff;
    assign quiet_active_out  = quiet_ff;

endmodule // spwm_top

// file: tb/spwm_asserts.sv
// concurrent checks on the ports of the stepper pwm block
`timescale 1ns/1ns
module spwm_asserts #(
    parameter int STST_CLKS = 64
) (
    // clock, reset and enable
    input wire logic        clk_in,
    input wire logic        nrst_in,
    input wire logic        ce_in,
    // register access
    input wire logic        reg_wr_en_in,
    input wire logic        reg_rd_en_in,
    input wire logic [6:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    // motion and status
    input wire logic        step_in,
    input wire logic        quiet_mode_in,
    input wire logic [4:0]  hold_run_current_setting_hold_in,
    input wire logic        pwm_tick_out,
    input wire logic [4:0]  cs_actual_out,
    input wire logic        standstill_out,
    input wire logic        quiet_active_out
);
    // ----------------------------------------
    // idle counter and access decode
    // ----------------------------------------
    int   idle_ff;
    logic rd_st, rd_cf, wr_cf;
    assign rd_st = ce_in && reg_rd_en_in && reg_addr_in == 7'h6f;
    assign rd_cf = ce_in && reg_rd_en_in && reg_addr_in == 7'h70;
    assign wr_cf = ce_in && reg_wr_en_in && reg_addr_in == 7'h70;
    // counts only enabled edges, since a low enable freezes the design's timer too
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            idle_ff <= 0;
        end else if (ce_in) begin
            idle_ff <= step_in ? 0 : idle_ff + 1;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    rsvd_zero_a: assert property (rd_st |=> reg_rdata_out[29:21] == 9'h0 && !reg_rdata_out[15])
        else $error("reserved status bits set");
    quiet_copy_a: assert property (ce_in |=> quiet_active_out == $past(quiet_mode_in))
        else $error("quiet indicator wrong");
    hold_scale_a: assert property ($past(nrst_in) && standstill_out && $past(standstill_out)
        && $stable(hold_run_current_setting_hold_in) |-> cs_actual_out == hold_run_current_setting_hold_in)
        else $error("standstill scale not hold");
    step_clear_a: assert property (ce_in && step_in |=> !standstill_out)
        else $error("standstill kept after step");
    stst_time_a: assert property ($rose(standstill_out) |-> idle_ff inside {[STST_CLKS - 2:STST_CLKS + 2]})
        else $error("standstill rose at wrong time");
    stst_due_a: assert property (idle_ff == STST_CLKS + 3 |-> standstill_out)
        else $error("standstill late");
    tick_pulse_a: assert property (pwm_tick_out |=> !pwm_tick_out)
        else $error("tick wider than one cycle");
    conf_back_a: assert property (wr_cf ##1 rd_cf |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("config readback wrong");
    frozen_state_a: assert property (!ce_in |=> $stable(standstill_out) && $stable(cs_actual_out)
        && $stable(reg_rdata_out) && $stable(quiet_active_out) && $stable(pwm_tick_out))
        else $error("state moved with enable low");

    stst_c: cover property ($rose(standstill_out));
    conf_c: cover property (wr_cf ##1 rd_cf);
    tick_c: cover property (pwm_tick_out && quiet_active_out);
endmodule // spwm_asserts

bind spwm_top spwm_asserts #(.STST_CLKS(STST_CLKS)) u_asserts (.clk_in, .nrst_in, .ce_in,
    .reg_wr_en_in, .reg_rd_en_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .step_in,
    .quiet_mode_in, .hold_run_current_setting_hold_in, .pwm_tick_out, .cs_actual_out,
    .standstill_out, .quiet_active_out);

// file: tb/spwm_coil_model.sv
// coil current feedback model for the stepper pwm block
`timescale 1ns/1ns
module spwm_coil_model #(
    parameter logic [7:0] TARGET = 8'h00
) (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       tick_in,
    input  wire logic [7:0] amp_in,
    output logic            above_out,
    output logic            below_out
);
    // coil current only settles once per pwm period, so feedback moves on ticks
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            above_out <= 1'b0;
            below_out <= 1'b0;
        end else if (tick_in) begin
            above_out <= amp_in > TARGET;
            below_out <= amp_in < TARGET;
        end
    end
endmodule // spwm_coil_model

// file: tb/spwm_top_tb.sv
// self-checking bench for the stepper pwm block
`timescale 1ns/1ns
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin fails++; \
    $display("BAD %0t got %h exp %h", $time, (g), (x)); end end
module spwm_top_tb;
    localparam int STST = 256;
    logic        clk_in = 1'b0, nrst_in = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, ce = 1'b1;
    logic        step = 1'b0, quiet = 1'b0, above, below, tick, stst, qact;
    logic [6:0]  addr = 7'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0]  otp = 8'h0, thresh = 8'h1, amp, ofs;
    logic [4:0]  hold = 5'h0, run = 5'h0, cs;
    logic [14:0] flags = 15'h0;
    logic [63:0] ent, expq[$];
    int          step_per = 0, sc = 0, fails = 0, check_count = 0, n, e, k;
    int          per[4] = '{1024, 683, 512, 410};

    always #5 clk_in = ~clk_in;

    spwm_top #(.STST_CLKS(STST)) dut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce),
        .reg_wr_en_in(wr), .reg_rd_en_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .otp_gradient_in(otp), .step_in(step), .quiet_mode_in(quiet),
        .hold_run_current_setting_hold_in(hold), .hold_run_current_setting_run_in(run),
        .cur_above_in(above), .cur_below_in(below), .low_thresh_in(thresh),
        .low_flags_in(flags), .pwm_tick_out(tick), .pwm_amplitude_out(amp),
        .cs_actual_out(cs), .standstill_out(stst), .quiet_active_out(qact));
    spwm_coil_model u_coil (.clk_in(clk_in), .nrst_in(nrst_in), .tick_in(tick),
        .amp_in(amp), .above_out(above), .below_out(below));

    // ----------------------------------------
    // step source and read result monitor
    // ----------------------------------------
    always @(posedge clk_in) begin
        sc <= (step_per > 0 && sc + 1 >= step_per) ? 0 : sc + 1;
        step <= step_per > 0 && sc + 1 >= step_per;
        rd_d <= rd;
        if (rd_d) begin
            ent = expq.pop_front();
            `CHK(rdata & ent[63:32], ent[31:0])
        end
    end

    task automatic rd_reg(input logic [6:0] a, input logic [31:0] m, input logic [31:0] x);
        rd <= 1'b1;
        addr <= a;
        expq.push_back({m, x});
        @(posedge clk_in);
        rd <= 1'b0;
        @(posedge clk_in);
    endtask

    // write then read straight back, so every write is also checked
    task automatic wr_conf(input logic [31:0] d);
        wr <= 1'b1;
        addr <= 7'h70;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
        rd_reg(7'h70, 32'hffffffff, d);
    endtask

    task automatic wait_ticks(input int t);
        n = 0;
        e = 0;
        while (e < t) begin
            @(posedge clk_in);
            n++;
            if (tick) e++;
            if (n > 50000) begin
                fails++;
                $display("BAD %0t no pwm tick", $time);
                tally_and_finish();
            end
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(27));
        otp <= 8'($urandom);
        hold <= 5'($urandom);
        run <= 5'($urandom);
        thresh <= 8'($urandom_range(30, 1));
        flags <= 15'($urandom);
        ofs = 8'($urandom_range(255, 1));
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd_reg(7'h70, 32'hffffffff, {16'h000c, otp, 8'h24});
        rd_reg(7'h72, 32'hffffffff, {8'h0, otp, 16'h0024});
        rd_reg(7'h6f, 32'hffffffff, {11'h0, run, 1'b0, flags});
        rd_reg(7'h10, 32'hffffffff, 32'h0);
        $display("power-up defaults done");
        for (int s = 0; s < 4; s++) begin
            wr_conf({14'h0, 2'(s), 16'h0024});
            wait_ticks(2);
            k = 0;
            e = 0;
            while (e < 2 && k < 3000) begin
                @(posedge clk_in);
                k++;
                if (tick) e++;
            end
            `CHK(k >= per[s] - 1 && k <= per[s] + 1, 1'b1)
        end
        $display("pwm rate select done");
        quiet <= 1'b1;
        wr_conf({14'h0, 2'b11, 8'h00, ofs});
        repeat (STST + 8) @(posedge clk_in);
        `CHK(amp, 8'((int'(ofs) * (int'(hold) + 1)) / 32))
        rd_reg(7'h6f, 32'hffffffff, {2'b11, 9'h0, hold, 1'b0, flags});
        wr_conf({14'h0, 2'b11, 8'h05, ofs});
        step_per <= 100;
        repeat (400) @(posedge clk_in);
        e = (int'(ofs) * (int'(run) + 1)) / 32 + 12;
        `CHK(amp, 8'(e > 255 ? 255 : e))
        `CHK(cs, run)
        $display("feed-forward amplitude done");
        quiet <= 1'b0;
        wr_conf({12'h0, 4'b1011, 16'h0528});
        wr_conf({12'h0, 4'b1111, 16'h0528});
        rd_reg(7'h72, 32'hffffffff, 32'h00050028);
        quiet <= 1'b1;
        wait_ticks(60);
        rd_reg(7'h72, 32'hffffffff, 32'h0);
        `CHK(amp, 8'h00)
        quiet <= 1'b0;
        wr_conf({12'h0, 4'b0011, 16'h0000});
        wr_conf({12'h0, 4'b0111, 16'h0000});
        quiet <= 1'b1;
        wait_ticks(40);
        rd_reg(7'h72, 32'h000000ff, {24'h0, thresh});
        `CHK(amp, thresh)
        $display("automatic scaling done");
        // a low enable must freeze the standstill timer along with everything else
        step_per <= 0;
        ce <= 1'b0;
        repeat (300) @(posedge clk_in);
        `CHK(stst, 1'b0)
        ce <= 1'b1;
        repeat (300) @(posedge clk_in);
        `CHK(stst, 1'b1)
        $display("clock enable freeze done");
        tally_and_finish();
    end
endmodule // spwm_top_tb
